/* File: tod_defs.svh */
`ifndef TOD_DEFS_SVH
`define TOD_DEFS_SVH

// time-base source select codes
`define TOD_SRC_EXT          2'h0
`define TOD_SRC_LPO          2'h1
`define TOD_SRC_IREF         2'h2

// prescale codes
`define TOD_PS_1K            3'h0
`define TOD_PS_32768         3'h1
`define TOD_PS_32000         3'h2
`define TOD_PS_38400         3'h3
`define TOD_PS_4M9152        3'h4
`define TOD_PS_4M            3'h5
`define TOD_PS_8M            3'h6
`define TOD_PS_16M           3'h7

// reset values of the configuration
`define TOD_RST_SRC          2'h0
`define TOD_RST_PS           3'h1

// first divider stage: input edges per clock output period
`define TOD_DIV1_4M9152      9'h080
`define TOD_DIV1_4M          9'h07d
`define TOD_DIV1_8M          9'h0fa
`define TOD_DIV1_16M         9'h1f4
`define TOD_DIV1_NONE        9'h001

// second divider stage: edges per 4 Hz tick
`define TOD_DIV2_1K          14'h00fa
`define TOD_DIV2_32768       14'h2000
`define TOD_DIV2_32000       14'h1f40
`define TOD_DIV2_38400       14'h2580

// cycles for a match write to take effect
`define TOD_MATCH_SYNC       2'h3

`endif

/* File: tod_pkg.sv */
package tod_pkg;

  typedef enum logic [1:0]
  {
    SRC_EXT  = 2'h0,
    SRC_LPO  = 2'h1,
    SRC_IREF = 2'h2,
    SRC_NONE = 2'h3
  } source_t;

  typedef struct packed
  {
    logic       module_enable;
    logic       clock_output_enable;
    logic [1:0] time_base_source_select;
    logic [2:0] time_base_prescale;
  } control_t;

  // shared shape of flags, irq enables and write-one-to-clear strobes
  typedef struct packed
  {
    logic match;
    logic one_second;
    logic quarter_second;
  } event_bits_t;

endpackage : tod_pkg

/* File: edge_sync.sv */
`timescale 1ns/10ps
module edge_sync
(
  input  wire logic i_clock,
  input  wire logic i_rst,
  input  wire logic i_async,
  output logic      o_level,
  output logic      o_rise
);
  logic meta;
  logic prev;

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      meta    <= 1'b0;
      o_level <= 1'b0;
      prev    <= 1'b0;
    end
    else
    begin
      meta    <= i_async;
      o_level <= meta;
      prev    <= o_level;
    end
  end

  assign o_rise = o_level & ~prev;

endmodule : edge_sync

/* File: tod_prescaler.sv */
`timescale 1ns/10ps
`include "tod_defs.svh"
module tod_prescaler
  import tod_pkg::*;
#(
  parameter logic [13:0] DIV2_1K    = `TOD_DIV2_1K,
  parameter logic [13:0] DIV2_32768 = `TOD_DIV2_32768,
  parameter logic [13:0] DIV2_32000 = `TOD_DIV2_32000,
  parameter logic [13:0] DIV2_38400 = `TOD_DIV2_38400
)
(
  input  wire logic       i_clock,
  input  wire logic       i_rst,
  input  wire logic       i_run,
  input  wire logic       i_edge,
  input  wire logic       i_level,
  input  wire logic       i_out_enable,
  input  wire logic [2:0] i_prescale,
  output logic            o_tick,
  output logic            o_clock_output
);
  logic [8:0]  stage1;
  logic [13:0] stage2;
  logic [8:0]  ratio1;
  logic [13:0] ratio2;

  function automatic logic [8:0] first_ratio(input logic [2:0] code);
    case (code)
      `TOD_PS_4M9152: first_ratio = `TOD_DIV1_4M9152;
      `TOD_PS_4M:     first_ratio = `TOD_DIV1_4M;
      `TOD_PS_8M:     first_ratio = `TOD_DIV1_8M;
      `TOD_PS_16M:    first_ratio = `TOD_DIV1_16M;
      default:        first_ratio = `TOD_DIV1_NONE;
    endcase
  endfunction : first_ratio

  function automatic logic [13:0] second_ratio(input logic [2:0] code);
    case (code)
      `TOD_PS_1K:     second_ratio = DIV2_1K;
      `TOD_PS_32768:  second_ratio = DIV2_32768;
      `TOD_PS_38400,
      `TOD_PS_4M9152: second_ratio = DIV2_38400;
      default:        second_ratio = DIV2_32000;
    endcase
  endfunction : second_ratio

  assign ratio1 = first_ratio(i_prescale);
  assign ratio2 = second_ratio(i_prescale);

  // two stages: high inputs first come down to 32 or 38.4 kHz, then to 4 Hz
  always_ff @(posedge i_clock)
  begin
    if (i_rst || !i_run)
    begin
      stage1 <= 9'h000;
      stage2 <= 14'h0000;
      o_tick <= 1'b0;
    end
    else
    begin
      o_tick <= 1'b0;
      if (i_edge)
      begin
        if (stage1 == ratio1 - 9'h001)
        begin
          stage1 <= 9'h000;
          if (stage2 == ratio2 - 14'h0001)
          begin
            stage2 <= 14'h0000;
            o_tick <= 1'b1;
          end
          else
          begin
            stage2 <= stage2 + 14'h0001;
          end
        end
        else
        begin
          stage1 <= stage1 + 9'h001;
        end
      end
    end
  end

  // divided output is only as clean as the sampling of the input allows
  always_ff @(posedge i_clock)
  begin
    if (i_rst || !i_out_enable)
    begin
      o_clock_output <= 1'b0;
    end
    else
    begin
      case (i_prescale)
        `TOD_PS_1K:     o_clock_output <= 1'b0;
        `TOD_PS_32768,
        `TOD_PS_32000,
        `TOD_PS_38400:  o_clock_output <= i_level;
        default:        o_clock_output <= (stage1 < {1'b0, ratio1[8:1]});
      endcase
    end
  end

endmodule : tod_prescaler

/* File: quarter_second_time_counter.sv */
// How it works
// - a match write while one is still pending is ignored
// - source field 00 external, 01 low-power 1 kHz, 10 internal reference
// - prescaler divides selected input down to a 4 Hz counter tick
// - divided clock output driven only while its enable bit is set
// - codes 000 to 011: no output, or the low-frequency input itself
// - codes 100 to 111: input divided down to 38.4 or 32 kHz
// - flags set whenever their event occurs, whatever the irq enables
// - a flag clears by writing one; it blocks new interrupts till then
// - quarter-second flag on every count; irq when its enable is set
// - one-second flag when the low two count bits wrap to zero
// - coinciding quarter and one-second events give one shared request
// - match enabled and counter reaching match value sets the match flag
// - on match the upper six count bits clear, low two stay
// - match works fully with its interrupt enable clear, minus the request
// - reset: disabled, source 00, prescale 001, irq and match enables clear
// - reset clears the counter and the match value
// - the shared request holds while any enabled flag stays set
// - eight-bit counter counts each 4 Hz tick and wraps to zero
// - match value compares against the upper six count bits
// - count restart clears the counter and the 4 Hz generator
// - a match write snapshots the counter's low two bits
`timescale 1ns/10ps
`include "tod_defs.svh"
module quarter_second_time_counter
  import tod_pkg::*;
#(
  parameter logic [13:0] DIV2_1K    = `TOD_DIV2_1K,
  parameter logic [13:0] DIV2_32768 = `TOD_DIV2_32768,
  parameter logic [13:0] DIV2_32000 = `TOD_DIV2_32000,
  parameter logic [13:0] DIV2_38400 = `TOD_DIV2_38400
)
(
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  input  wire logic        i_external_oscillator_clock,
  input  wire logic        i_low_power_oscillator,
  input  wire logic        i_internal_reference_clock,
  input  wire control_t    i_control,
  input  wire logic        i_count_restart,
  input  wire event_bits_t i_irq_enable,
  input  wire logic        i_match_function_enable,
  input  wire logic        i_match_write,
  input  wire logic [5:0]  i_match_write_value,
  input  wire event_bits_t i_flag_clear,
  output event_bits_t      o_flags,
  output logic             o_match_write_pending,
  output logic [7:0]       o_match_value,
  output logic [7:0]       o_quarter_second_count,
  output logic             o_irq,
  output logic             o_clock_output
);
  localparam int MATCH_SYNC_MAX = 4;

  control_t    cfg;
  event_bits_t irq_enable;
  logic        match_function_enable;
  logic [2:0]  src_async;
  logic [2:0]  src_level;
  logic [2:0]  src_rise;
  logic        sel_level;
  logic        sel_rise;
  logic        tick;
  logic        run;
  logic [7:0]  inc_count;
  logic [7:0]  next_count;
  logic        match_event;
  event_bits_t set_bits;
  logic [5:0]  staged_value;
  logic [1:0]  staged_low;
  logic [1:0]  sync_wait;

  assign src_async = {i_internal_reference_clock, i_low_power_oscillator,
                      i_external_oscillator_clock};

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_src
      edge_sync u_sync
      (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_async (src_async[g]),
        .o_level (src_level[g]),
        .o_rise  (src_rise[g])
      );
    end
  endgenerate

  // source and prescale only follow software while disabled
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      cfg.module_enable           <= 1'b0;
      cfg.clock_output_enable     <= 1'b0;
      cfg.time_base_source_select <= `TOD_RST_SRC;
      cfg.time_base_prescale      <= `TOD_RST_PS;
      irq_enable                  <= '0;
      match_function_enable       <= 1'b0;
    end
    else
    begin
      cfg.module_enable       <= i_control.module_enable;
      cfg.clock_output_enable <= i_control.clock_output_enable;
      irq_enable              <= i_irq_enable;
      match_function_enable   <= i_match_function_enable;
      if (!cfg.module_enable)
      begin
        cfg.time_base_source_select <= i_control.time_base_source_select;
        cfg.time_base_prescale      <= i_control.time_base_prescale;
      end
    end
  end

  always_comb
  begin
    case (source_t'(cfg.time_base_source_select))
      SRC_EXT:  begin sel_level = src_level[0]; sel_rise = src_rise[0]; end
      SRC_LPO:  begin sel_level = src_level[1]; sel_rise = src_rise[1]; end
      SRC_IREF: begin sel_level = src_level[2]; sel_rise = src_rise[2]; end
      default:  begin sel_level = 1'b0;         sel_rise = 1'b0;         end
    endcase
  end

  assign run = cfg.module_enable & ~i_count_restart;

  tod_prescaler
  #(
    .DIV2_1K    (DIV2_1K),
    .DIV2_32768 (DIV2_32768),
    .DIV2_32000 (DIV2_32000),
    .DIV2_38400 (DIV2_38400)
  )
  u_prescaler
  (
    .i_clock        (i_clock),
    .i_rst          (i_rst),
    .i_run          (run),
    .i_edge         (sel_rise),
    .i_level        (sel_level),
    .i_out_enable   (cfg.clock_output_enable),
    .i_prescale     (cfg.time_base_prescale),
    .o_tick         (tick),
    .o_clock_output (o_clock_output)
  );

  // match fires on entering the match value, so a value of zero cannot
  // retrigger on every tick after the upper bits are cleared
  assign inc_count   = o_quarter_second_count + 8'h01;
  assign match_event = tick && match_function_enable
                       && (inc_count[7:2] == o_match_value[7:2])
                       && (o_quarter_second_count[7:2] != o_match_value[7:2]);
  assign next_count  = match_event ? {6'h00, inc_count[1:0]} : inc_count;

  always_ff @(posedge i_clock)
  begin
    if (i_rst || !cfg.module_enable || i_count_restart)
    begin
      o_quarter_second_count <= 8'h00;
    end
    else if (tick)
    begin
      o_quarter_second_count <= next_count;
    end
  end

  assign set_bits.quarter_second = tick;
  assign set_bits.one_second     = tick && (inc_count[1:0] == 2'h0);
  assign set_bits.match          = match_event;

  // a new event wins over a clear in the same cycle
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      o_flags <= '0;
    end
    else
    begin
      o_flags <= (o_flags & ~i_flag_clear) | set_bits;
    end
  end

  // one shared level request, held until every enabled flag is cleared
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      o_irq <= 1'b0;
    end
    else
    begin
      o_irq <= |(o_flags & irq_enable);
    end
  end

  // match writes go through a short staging delay, mirroring the crossing
  // into the time-base domain; software must poll the pending bit
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      staged_value          <= 6'h00;
      staged_low            <= 2'h0;
      sync_wait             <= 2'h0;
      o_match_write_pending <= 1'b0;
      o_match_value         <= 8'h00;
    end
    else if (o_match_write_pending)
    begin
      if (sync_wait == 2'h1)
      begin
        o_match_value         <= {staged_value, staged_low};
        o_match_write_pending <= 1'b0;
      end
      sync_wait <= sync_wait - 2'h1;
    end
    else if (i_match_write)
    begin
      staged_value          <= i_match_write_value;
      staged_low            <= o_quarter_second_count[1:0];
      sync_wait             <= `TOD_MATCH_SYNC;
      o_match_write_pending <= 1'b1;
    end
  end

  property p_write_ignored;
    @(posedge i_clock) disable iff (i_rst)
    (o_match_write_pending && i_match_write) |=> $stable(staged_value);
  endproperty
  a_write_ignored: assert property (p_write_ignored)
    else $error("match write taken while pending");

  property p_pending_clears;
    @(posedge i_clock) disable iff (i_rst)
    $rose(o_match_write_pending) |-> o_match_write_pending [*3] ##1 !o_match_write_pending;
  endproperty
  a_pending_clears: assert property (p_pending_clears)
    else $error("pending flag did not clear after three cycles");

  property p_pending_bounded;
    @(posedge i_clock) disable iff (i_rst)
    o_match_write_pending |-> ##[1:MATCH_SYNC_MAX] !o_match_write_pending;
  endproperty
  a_pending_bounded: assert property (p_pending_bounded)
    else $error("match write never completed");

  property p_snapshot;
    @(posedge i_clock) disable iff (i_rst)
    (!o_match_write_pending && i_match_write)
      |=> staged_low == $past(o_quarter_second_count[1:0]);
  endproperty
  a_snapshot: assert property (p_snapshot)
    else $error("low bits not captured on match write");

  property p_quarter_flag;
    @(posedge i_clock) disable iff (i_rst)
    tick |=> o_flags.quarter_second && o_quarter_second_count != $past(o_quarter_second_count);
  endproperty
  a_quarter_flag: assert property (p_quarter_flag)
    else $error("tick did not set quarter flag or advance count");

  property p_second_flag;
    @(posedge i_clock) disable iff (i_rst)
    (tick && !o_flags.one_second) |=> o_flags.one_second == (o_quarter_second_count[1:0] == 2'h0);
  endproperty
  a_second_flag: assert property (p_second_flag)
    else $error("one-second flag wrong for the new count");

  property p_match_reset;
    @(posedge i_clock) disable iff (i_rst)
    (match_event && cfg.module_enable && !i_count_restart)
      |=> o_flags.match && o_quarter_second_count[7:2] == 6'h00;
  endproperty
  a_match_reset: assert property (p_match_reset)
    else $error("match did not clear upper count bits");

  property p_no_match_disabled;
    @(posedge i_clock) disable iff (i_rst)
    !match_function_enable |-> !match_event;
  endproperty
  a_no_match_disabled: assert property (p_no_match_disabled)
    else $error("match while match function disabled");

  property p_irq_follows;
    @(posedge i_clock) disable iff (i_rst)
    (|(o_flags & irq_enable)) |=> o_irq;
  endproperty
  a_irq_follows: assert property (p_irq_follows)
    else $error("shared request missing while an enabled flag is set");

  // a set flag left uncleared keeps the request up, so it cannot pulse again
  property p_irq_quiet;
    @(posedge i_clock) disable iff (i_rst)
    !(|(o_flags & irq_enable)) |=> !o_irq;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet)
    else $error("shared request raised with no enabled flag set");

  property p_restart;
    @(posedge i_clock) disable iff (i_rst)
    i_count_restart |=> o_quarter_second_count == 8'h00 && !tick;
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart did not clear counter and time base");

  property p_clock_out_off;
    @(posedge i_clock) disable iff (i_rst)
    !cfg.clock_output_enable |=> !o_clock_output;
  endproperty
  a_clock_out_off: assert property (p_clock_out_off)
    else $error("clock output driven while disabled");

  property p_reset_defaults;
    @(posedge i_clock)
    i_rst |=> cfg.time_base_prescale == `TOD_RST_PS && !cfg.module_enable && o_match_value == 8'h00;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults)
    else $error("reset defaults not loaded");

  c_second_tick: cover property (@(posedge i_clock) disable iff (i_rst)
    set_bits.one_second && set_bits.quarter_second);
  c_match: cover property (@(posedge i_clock) disable iff (i_rst) match_event);
  c_write_refused: cover property (@(posedge i_clock) disable iff (i_rst)
    o_match_write_pending && i_match_write);
  c_irq: cover property (@(posedge i_clock) disable iff (i_rst) $rose(o_irq));

endmodule : quarter_second_time_counter

/* File: quarter_second_time_counter_bench.sv */
`timescale 1ns/10ps
module quarter_second_time_counter_bench;
  import tod_pkg::*;
  localparam logic [13:0] DIV    = 14'h0004;
  localparam logic [21:0] M_CO   = 22'h010000;
  localparam logic [21:0] M_PEND = 22'h020000;
  localparam logic [21:0] M_MV   = 22'h00ff00;
  localparam logic [21:0] M_CNT  = 22'h0000ff;
  typedef struct packed {logic [7:0] count; event_bits_t flags; logic irq;} tick_note_t;
  typedef struct packed {logic [21:0] mask; logic [21:0] value;} probe_note_t;
  logic        i_clock = 1'b0;
  logic        i_rst = 1'b1;
  logic [2:0]  src = 3'h0;
  control_t    i_control = '0;
  logic        i_count_restart = 1'b0;
  event_bits_t i_irq_enable = '0;
  logic        i_match_function_enable = 1'b0;
  logic        i_match_write = 1'b0;
  logic [5:0]  i_match_write_value = 6'h00;
  event_bits_t i_flag_clear = '0;
  event_bits_t o_flags;
  logic        o_match_write_pending;
  logic        o_irq;
  logic        o_clock_output;
  logic [7:0]  o_match_value;
  logic [7:0]  o_quarter_second_count;
  logic        probe_req = 1'b0;
  tick_note_t  tq[$];
  probe_note_t pq[$];
  int          n_fail = 0;
  int          comparisons = 0;
  logic [7:0]  cnt = 8'h00;
  event_bits_t flg = '0;
  event_bits_t ien = '0;
  logic [5:0]  mval = 6'h00;
  logic        men = 1'b0;
  int          pin = 0;
  logic [7:0]  last_cnt;
  logic        irq_due = 1'b0;
  logic        exp_irq = 1'b0;
  int          s1 [4] = '{128, 125, 250, 500};

  always #20 i_clock = ~i_clock;

  quarter_second_time_counter #(
    .DIV2_1K    (DIV),
    .DIV2_32768 (DIV),
    .DIV2_32000 (DIV),
    .DIV2_38400 (DIV)
  ) u_dut (
    .i_clock                     (i_clock),
    .i_rst                       (i_rst),
    .i_external_oscillator_clock (src[0]),
    .i_low_power_oscillator      (src[1]),
    .i_internal_reference_clock  (src[2]),
    .i_control                   (i_control),
    .i_count_restart             (i_count_restart),
    .i_irq_enable                (i_irq_enable),
    .i_match_function_enable     (i_match_function_enable),
    .i_match_write               (i_match_write),
    .i_match_write_value         (i_match_write_value),
    .i_flag_clear                (i_flag_clear),
    .o_flags                     (o_flags),
    .o_match_write_pending       (o_match_write_pending),
    .o_match_value               (o_match_value),
    .o_quarter_second_count      (o_quarter_second_count),
    .o_irq                       (o_irq),
    .o_clock_output              (o_clock_output)
  );

  task automatic check(input logic [21:0] seen, input logic [21:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up();
    if (n_fail == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up

  // counter changes are the results; irq is judged one sample later
  always @(posedge i_clock)
  begin
    tick_note_t  tn;
    probe_note_t pn;
    if (irq_due)
      check({21'h0, o_irq}, {21'h0, exp_irq});
    irq_due = 1'b0;
    if (!i_rst && o_quarter_second_count !== last_cnt)
    begin
      tn = (tq.size() > 0) ? tq.pop_front() : '1;
      check({11'h0, o_flags, o_quarter_second_count}, {11'h0, tn.flags, tn.count});
      exp_irq = tn.irq;
      irq_due = 1'b1;
    end
    last_cnt = o_quarter_second_count;
    if (probe_req)
    begin
      pn = pq.pop_front();
      check({o_flags, o_irq, o_match_write_pending, o_clock_output, o_match_value,
             o_quarter_second_count} & pn.mask, pn.value & pn.mask);
    end
  end

  task automatic probe(input logic [21:0] m, input logic [21:0] v);
    pq.push_back({m, v});
    @(negedge i_clock) probe_req = 1'b1;
    @(negedge i_clock) probe_req = 1'b0;
  endtask : probe

  task automatic model_tick();
    logic [7:0] nxt;
    nxt = cnt + 8'h01;
    flg.quarter_second = 1'b1;
    if (nxt[1:0] == 2'h0)
      flg.one_second = 1'b1;
    if (men && nxt[7:2] == mval && cnt[7:2] != mval)
    begin
      flg.match = 1'b1;
      nxt[7:2] = 6'h00;
    end
    cnt = nxt;
    tq.push_back({cnt, flg, |(flg & ien)});
  endtask : model_tick

  task automatic expect_clear();
    if (cnt != 8'h00)
      tq.push_back({8'h00, flg, |(flg & ien)});
    cnt = 8'h00;
  endtask : expect_clear

  // unselected sources toggle twice as fast, so a wrong select miscounts
  task automatic src_edges(input int n);
    repeat (2 * n)
    begin
      @(negedge i_clock) src = src ^ 3'h7;
      @(negedge i_clock);
      @(negedge i_clock) src = src ^ (3'h7 & ~(3'h1 << pin));
      @(negedge i_clock);
    end
  endtask : src_edges

  task automatic ticks(input int k, input logic rnd_clear);
    repeat (k)
    begin
      model_tick();
      src_edges(4);
      if (rnd_clear)
      begin
        @(negedge i_clock) i_flag_clear = event_bits_t'($urandom);
        flg = flg & ~i_flag_clear;
        @(negedge i_clock) i_flag_clear = '0;
      end
    end
  endtask : ticks

  task automatic clear_flags(input event_bits_t m);
    @(negedge i_clock) i_flag_clear = m;
    @(negedge i_clock) i_flag_clear = '0;
    flg = flg & ~m;
  endtask : clear_flags

  task automatic set_ien(input event_bits_t v);
    @(negedge i_clock) i_irq_enable = v;
    ien = v;
  endtask : set_ien

  task automatic configure(input logic [1:0] s, input logic [2:0] ps, input logic coe);
    @(negedge i_clock) i_control.module_enable = 1'b0;
    @(negedge i_clock) i_control = '{1'b0, coe, s, ps};
    expect_clear();
    @(negedge i_clock) i_control.module_enable = 1'b1;
    pin = int'(s);
  endtask : configure

  task automatic co_period(input logic hi);
    @(negedge i_clock) src[pin] = 1'b1;
    repeat (2) @(negedge i_clock);
    probe(M_CO, hi ? M_CO : 22'h0);
    src[pin] = 1'b0;
    repeat (2) @(negedge i_clock);
    probe(M_CO, 22'h0);
  endtask : co_period

  task automatic match_write(input logic [5:0] v);
    @(negedge i_clock)
    begin
      i_match_write = 1'b1;
      i_match_write_value = v;
    end
    @(negedge i_clock) i_match_write = 1'b0;
    probe(M_PEND, M_PEND);
    // second write lands on the last pending edge and must be dropped
    i_match_write = 1'b1;
    i_match_write_value = ~v;
    @(negedge i_clock) i_match_write = 1'b0;
    repeat (4) @(negedge i_clock);
    mval = v;
    probe(M_PEND | M_MV, {6'h00, v, cnt[1:0], 8'h00});
  endtask : match_write

  initial
  begin
    repeat (2) @(negedge i_clock);
    i_rst = 1'b0;
    void'($urandom(32'h8f86f08e));
    probe(22'h3fffff, 22'h0);
    configure(2'h1, 3'h0, 1'b0);
    ticks(5, 1'b0);
    clear_flags(3'h7);
    set_ien(3'h3);
    repeat (6)
    begin
      ticks(1, 1'b0);
      clear_flags(3'h1);
    end
    ticks(8, 1'b1);
    // source and prescale writes while enabled must not take
    @(negedge i_clock) i_control = '{1'b1, 1'b0, 2'h0, 3'h4};
    ticks(3, 1'b1);
    src_edges(2);
    @(negedge i_clock) i_count_restart = 1'b1;
    @(negedge i_clock) i_count_restart = 1'b0;
    expect_clear();
    src_edges(3);
    probe(M_CNT, 22'h0);
    model_tick();
    src_edges(1);
    for (int c = 0; c < 8; c++)
    begin
      configure(2'(c % 3), 3'(c % 4), c[2]);
      model_tick();
      repeat (4) co_period((c % 4 != 0) && c[2]);
    end
    for (int c = 4; c < 8; c++)
    begin
      configure(2'(c % 3), 3'(c), 1'b1);
      model_tick();
      src_edges(10);
      probe(M_CO, M_CO);
      src_edges(s1[c - 4] / 2);
      probe(M_CO, 22'h0);
      src_edges(s1[c - 4] * 4 - 10 - s1[c - 4] / 2);
    end
    configure(2'h1, 3'h0, 1'b0);
    clear_flags(3'h7);
    set_ien(3'h0);
    match_write(6'(1 + $urandom % 2));
    @(negedge i_clock) i_match_function_enable = 1'b1;
    men = 1'b1;
    ticks(12, 1'b1);
    set_ien(3'h4);
    match_write(cnt[7:2] + 6'(1 + $urandom % 2));
    ticks(12, 1'b1);
    repeat (4) @(negedge i_clock);
    check(22'(tq.size()), 22'h0);
    wrap_up();
  end

  initial
  begin
    #(70000 * 40);
    n_fail++;
    wrap_up();
  end
endmodule : quarter_second_time_counter_bench
